// >>> core/lowfreq_timer_calibration.sv
/*
  low-frequency timekeeping: rc calibration scheduler, eight timeout timers,
  millisecond tick counter, peripheral close, deep sleep wake, supervisor and
  high-voltage regulator output control.
  assumes lfClkPin, wake pins and supply monitors are asynchronous to clk.
*/
`default_nettype none
module lowfreq_timer_calibration #(
  parameter int unsigned TIMER_W    = 16,
  parameter int unsigned WAKE_PINS  = 8,
  parameter int unsigned CAL_CYCLES = lowfreq_timer_pkg::CAL_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   lfClkPin,
  input  wire logic                   calIntervalLoad,
  input  wire logic [6:0]             calIntervalValue,
  output logic [6:0]                  calInterval,
  output logic                        calBusy,
  output logic                        calDone,
  input  wire logic [7:0]             timerStart,
  input  wire logic [7:0]             timerStop,
  input  wire logic [TIMER_W-1:0]     timerPeriod,
  output logic [7:0]                  timerRunning,
  output logic [7:0]                  timeoutEvent,
  output logic [30:0]                 tickCount,
  input  wire logic [6:0]             periphOpen,
  output logic [6:0]                  periphEnable,
  input  wire logic                   sleepReq,
  input  wire logic [WAKE_PINS-1:0]   wakePins,
  input  wire logic [WAKE_PINS-1:0]   wakeSense,
  input  wire logic                   nearfieldPinA,
  input  wire logic                   nearfieldPinB,
  input  wire logic                   nearfieldSense,
  output logic                        deepSleep,
  output logic                        standby,
  output logic                        wakeReset,
  input  wire logic                   brownout,
  input  wire logic                   powerFail,
  output logic                        supplyHold,
  input  wire logic                   hvMode,
  input  wire logic                   regOutEnable,
  input  wire logic                   regVoltLoad,
  input  wire logic [2:0]             regVoltValue,
  output logic                        regLoadEnable,
  output logic [2:0]                  regVoltSel
);
  if (TIMER_W < 2 || TIMER_W > 32) $error("TIMER_W out of range");
  if (WAKE_PINS < 1) $error("WAKE_PINS must be positive");
  if (CAL_CYCLES < 1) $error("CAL_CYCLES must be positive");
  typedef enum logic [2:0] {
    ACTIVE = 3'h1,
    STANDBY = 3'h2,
    DEEP = 3'h4
  } pwr_e;
  localparam int unsigned SYNC_W = WAKE_PINS + 5;
  localparam int unsigned CAL_W  = $clog2(CAL_CYCLES + 1);

  // two-flop synchronisers for every pin input
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  logic [SYNC_W-1:0] pinsIn;
  assign pinsIn = {powerFail, brownout, nearfieldPinB, nearfieldPinA, lfClkPin, wakePins};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
    end else if (ce) begin
      syncA <= pinsIn;
      syncB <= syncA;
    end
  end

  logic lfLevel;
  logic [WAKE_PINS+1:0] wakeLevel;
  logic supplyBad;
  assign lfLevel   = syncB[WAKE_PINS];
  assign wakeLevel = {syncB[WAKE_PINS+2:WAKE_PINS+1], syncB[WAKE_PINS-1:0]};
  assign supplyBad = syncB[WAKE_PINS+3] | syncB[WAKE_PINS+4];

  // rc oscillator edge gives the real-time counter clock enable
  logic lfPrev;
  logic next_lfPrev;
  logic lfTick;
  always_comb begin
    next_lfPrev = lfLevel;
    lfTick = lfLevel & ~lfPrev;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lfPrev <= 1'b0;
    else if (ce) lfPrev <= next_lfPrev;
  end

  // calibration scheduler
  logic [12:0] quarterLf;
  logic [6:0]  quarterCnt;
  logic [CAL_W-1:0] calCnt;
  logic [12:0] next_quarterLf;
  logic [6:0]  next_quarterCnt;
  logic [6:0]  next_calInterval;
  logic [CAL_W-1:0] next_calCnt;
  logic next_calBusy;
  logic next_calDone;
  always_comb begin
    next_quarterLf   = quarterLf;
    next_quarterCnt  = quarterCnt;
    next_calInterval = calInterval;
    next_calCnt      = calCnt;
    next_calBusy     = calBusy;
    next_calDone     = 1'b0;
    // zero is not a legal interval and is ignored
    if (calIntervalLoad && calIntervalValue >= lowfreq_timer_pkg::CAL_INTERVAL_MIN) begin
      next_calInterval = calIntervalValue;
      next_quarterCnt  = '0;
      next_quarterLf   = '0; // first run waits a full new interval
    end else if (lfTick) begin
      if (quarterLf == 13'(lowfreq_timer_pkg::QUARTER_LF - 1)) begin
        next_quarterLf = '0;
        if (quarterCnt + 7'h01 >= calInterval) begin
          next_quarterCnt = '0;
          // a run still in progress is not restarted
          if (!calBusy) begin
            next_calBusy = 1'b1;
            next_calCnt  = CAL_W'(CAL_CYCLES - 1);
          end
        end else begin
          next_quarterCnt = quarterCnt + 7'h01;
        end
      end else begin
        next_quarterLf = quarterLf + 13'h0001;
      end
    end
    if (calBusy) begin
      if (calCnt == '0) begin
        next_calBusy = 1'b0;
        next_calDone = 1'b1;
      end else begin
        next_calCnt = calCnt - CAL_W'(1);
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quarterLf   <= '0;
      quarterCnt  <= '0;
      calInterval <= lowfreq_timer_pkg::CAL_INTERVAL_RST;
      calCnt      <= '0;
      calBusy     <= 1'b0;
      calDone     <= 1'b0;
    end else if (ce) begin
      quarterLf   <= next_quarterLf;
      quarterCnt  <= next_quarterCnt;
      calInterval <= next_calInterval;
      calCnt      <= next_calCnt;
      calBusy     <= next_calBusy;
      calDone     <= next_calDone;
    end
  end

  // shared prescalers: timer step and tick base
  logic [5:0] stepLf;
  logic [5:0] baseLf;
  logic       baseHalf;
  logic [5:0] next_stepLf;
  logic [5:0] next_baseLf;
  logic       next_baseHalf;
  logic [30:0] next_tickCount;
  logic timerStep;
  always_comb begin
    next_stepLf    = stepLf;
    next_baseLf    = baseLf;
    next_baseHalf  = baseHalf;
    next_tickCount = tickCount;
    timerStep      = 1'b0;
    if (lfTick) begin
      if (stepLf == 6'(lowfreq_timer_pkg::TIMER_STEP_LF - 1)) begin
        next_stepLf = '0;
        timerStep   = 1'b1;
      end else begin
        next_stepLf = stepLf + 6'h01;
      end
      if (baseLf == 6'(lowfreq_timer_pkg::TICK_BASE_LF - 1)) begin
        next_baseLf = '0;
        if (baseHalf == 1'(lowfreq_timer_pkg::TICK_BASES_MS - 1)) begin
          next_baseHalf  = 1'b0;
          // wraps naturally, never gated by power state
          next_tickCount = tickCount + 31'h00000001;
        end else begin
          next_baseHalf = baseHalf + 1'b1;
        end
      end else begin
        next_baseLf = baseLf + 6'h01;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stepLf    <= '0;
      baseLf    <= '0;
      baseHalf  <= 1'b0;
      tickCount <= '0;
    end else if (ce) begin
      stepLf    <= next_stepLf;
      baseLf    <= next_baseLf;
      baseHalf  <= next_baseHalf;
      tickCount <= next_tickCount;
    end
  end

  // eight timeout timers
  pwr_e pwr;
  pwr_e next_pwr;
  genvar gi;
  generate
    for (gi = 0; gi < lowfreq_timer_pkg::NUM_TIMERS; gi++) begin : g_timer
      logic [TIMER_W-1:0] remain;
      logic [TIMER_W-1:0] next_remain;
      logic next_run;
      logic next_evt;
      always_comb begin
        next_remain = remain;
        next_run    = timerRunning[gi];
        next_evt    = 1'b0;
        if (timerStop[gi] || pwr == DEEP) begin
          next_run = 1'b0;
        end else if (timerStart[gi]) begin
          // a zero period still waits one step
          next_remain = timerPeriod;
          next_run    = 1'b1;
        end else if (timerRunning[gi] && timerStep) begin
          if (remain <= TIMER_W'(1)) begin
            next_run    = 1'b0;
            next_evt    = 1'b1;
            next_remain = '0;
          end else begin
            next_remain = remain - TIMER_W'(1);
          end
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          remain           <= '0;
          timerRunning[gi] <= 1'b0;
          timeoutEvent[gi] <= 1'b0;
        end else if (ce) begin
          remain           <= next_remain;
          timerRunning[gi] <= next_run;
          timeoutEvent[gi] <= next_evt;
        end
      end
    end
  endgenerate

  // power state, wake and supervisor
  logic [WAKE_PINS+1:0] wakeHeld;
  logic [WAKE_PINS+1:0] next_wakeHeld;
  logic [WAKE_PINS+1:0] senseMask;
  logic next_wakeReset;
  logic next_supplyHold;
  logic [6:0] next_periphEnable;
  assign senseMask = {nearfieldSense, nearfieldSense, wakeSense};
  always_comb begin
    next_pwr          = pwr;
    next_wakeHeld     = wakeHeld;
    next_wakeReset    = 1'b0;
    next_supplyHold   = supplyBad;
    next_periphEnable = periphOpen;
    case (pwr)
      ACTIVE: begin
        if (sleepReq) begin
          next_pwr      = DEEP;
          next_wakeHeld = wakeLevel; // reference levels for change detect
        end
      end
      STANDBY: begin
        if (sleepReq) begin
          next_pwr      = DEEP;
          next_wakeHeld = wakeLevel;
        end else if (periphOpen != 7'h00) begin
          next_pwr = ACTIVE;
        end
      end
      DEEP: begin
        next_periphEnable = 7'h00;
        if (|((wakeLevel ^ wakeHeld) & senseMask)) begin
          next_pwr       = STANDBY;
          next_wakeReset = 1'b1;
        end
      end
      default: next_pwr = ACTIVE;
    endcase
    // supervisor overrides: bad supply closes all peripherals and parks the block in standby
    if (supplyBad) begin
      next_pwr          = STANDBY;
      next_periphEnable = 7'h00;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr          <= ACTIVE;
      wakeHeld     <= '0;
      wakeReset    <= 1'b0;
      supplyHold   <= 1'b1;
      periphEnable <= '0;
    end else if (ce) begin
      pwr          <= next_pwr;
      wakeHeld     <= next_wakeHeld;
      wakeReset    <= next_wakeReset;
      supplyHold   <= next_supplyHold;
      periphEnable <= next_periphEnable;
    end
  end
  assign deepSleep = (pwr == DEEP);
  assign standby   = (pwr == STANDBY);

  // regulated output in high-voltage mode
  logic [2:0] next_regVoltSel;
  logic next_regLoadEnable;
  always_comb begin
    next_regVoltSel = regVoltSel;
    // codes above 3.3 V are ignored so the selection stays legal
    if (regVoltLoad && regVoltValue <= lowfreq_timer_pkg::VSEL_3V3) begin
      next_regVoltSel = regVoltValue;
    end
    next_regLoadEnable = hvMode & regOutEnable & ~supplyBad;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regVoltSel    <= lowfreq_timer_pkg::VSEL_1V8;
      regLoadEnable <= 1'b0;
    end else if (ce) begin
      regVoltSel    <= next_regVoltSel;
      regLoadEnable <= next_regLoadEnable;
    end
  end
endmodule // lowfreq_timer_calibration
`default_nettype wire

// >>> core/lowfreq_timer_pkg.sv
/*
  constants for the low-frequency timekeeping and power-state block.
  assumes a 20 MHz system clock and a 32.768 kHz rc oscillator output pin.
*/
`default_nettype none
package lowfreq_timer_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned LF_HZ           = 32768;
  localparam int unsigned CAL_TIME_US     = 33000;
  localparam int unsigned CAL_CYCLES      = (CLK_HZ / 1000) * (CAL_TIME_US / 1000);
  localparam int unsigned QUARTER_LF      = LF_HZ / 4;
  localparam logic [6:0]  CAL_INTERVAL_RST = 7'h20;
  localparam logic [6:0]  CAL_INTERVAL_MIN = 7'h01;
  localparam int unsigned TIMER_STEP_US   = 976;
  localparam int unsigned TIMER_STEP_LF   = (TIMER_STEP_US * LF_HZ + 500000) / 1000000;
  localparam int unsigned TICK_BASE_US    = 488;
  localparam int unsigned TICK_BASE_LF    = (TICK_BASE_US * LF_HZ + 500000) / 1000000;
  localparam int unsigned TICK_BASES_MS   = 2;
  localparam int unsigned NUM_TIMERS      = 8;
  localparam int unsigned TICK_W          = 31;
  localparam int unsigned NUM_PERIPH      = 7;
  // regulated output codes: 1.8, 2.1, 2.4, 2.7, 3.0, 3.3 V
  localparam logic [2:0]  VSEL_1V8 = 3'h0;
  localparam logic [2:0]  VSEL_3V3 = 3'h5;
endpackage
`default_nettype wire

// >>> tb/lowfreq_timer_calibration_tb_top.sv
/*
  self-checking bench for lowfreq_timer_calibration: strobes and levels with expected values.
  assumes the monitor is compiled first; lf clock runs at half the system clock to keep runs short.
*/
`default_nettype none
`define CHK(s, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", s, e, g); end end
`define WAITF(c, l) n = 0; while ((c) !== 1'b1 && n < l) begin step(1); n++; end
module lowfreq_timer_calibration_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CALC = 20;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, lfClkPin = 1'b0, sleepReq = 1'b0;
  logic calIntervalLoad = 1'b0, calBusy, calDone, deepSleep, standby, wakeReset;
  logic [6:0] calIntervalValue = 7'h00, calInterval, periphOpen = 7'h00, periphEnable;
  logic [7:0] timerStart = 8'h00, timerStop = 8'h00, timerRunning, timeoutEvent;
  logic [7:0] wakePins = 8'h00, wakeSense = 8'h00;
  logic [15:0] timerPeriod = 16'h0003;
  logic [30:0] tickCount, t0;
  logic nearfieldPinA = 1'b0, nearfieldPinB = 1'b0, nearfieldSense = 1'b0;
  logic brownout = 1'b0, powerFail = 1'b0, supplyHold, hvMode = 1'b0, regOutEnable = 1'b0;
  logic regVoltLoad = 1'b0, regLoadEnable;
  logic [2:0] regVoltValue = 3'h0, regVoltSel;
  int err_count = 0, comparisons = 0, cyc = 0, n;
  lowfreq_timer_calibration #(.CAL_CYCLES(CALC)) dut_u (.*);
  always #25 clk = ~clk;
  always @(posedge clk) lfClkPin <= #1 ~lfClkPin;
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ceiling sits well above the single 16k-cycle calibration wait
  always @(posedge clk) begin
    cyc++;
    if (cyc == 25000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    step(1);
    `CHK("supplyHold", 1'b1, supplyHold)
    step(19);
    rst = 1'b0;
    `CHK("calInterval", 7'h20, calInterval)
    `CHK("regVoltSel", 3'h0, regVoltSel)
    step(4);
    `CHK("supplyHold", 1'b0, supplyHold)
    hvMode = 1'b1;
    step(2);
    `CHK("regLoadEnable", 1'b0, regLoadEnable)
    regOutEnable = 1'b1;
    step(1);
    `CHK("regLoadEnable", 1'b1, regLoadEnable)
    regVoltLoad = 1'b1;
    for (int v = 0; v < 8; v++) begin
      regVoltValue = 3'(v);
      step(1);
      `CHK("regVoltSel", (v > 5) ? 3'h5 : 3'(v), regVoltSel)
    end
    regVoltLoad = 1'b0;
    periphOpen = 7'h55;
    step(1);
    `CHK("periphEnable", 7'h55, periphEnable)
    periphOpen = 7'h2A;
    step(1);
    `CHK("periphEnable", 7'h2A, periphEnable)
    t0 = tickCount;
    step(640);
    `CHK("tickRate", 1'b1, (tickCount - t0) inside {31'h9, 31'hA, 31'hB})
    calIntervalLoad = 1'b1;
    step(1);
    `CHK("calInterval", 7'h20, calInterval)
    calIntervalValue = 7'h7F;
    step(1);
    `CHK("calInterval", 7'h7F, calInterval)
    calIntervalValue = 7'h01;
    step(1);
    calIntervalLoad = 1'b0;
    `CHK("calInterval", 7'h01, calInterval)
    t0 = tickCount;
    `WAITF(calBusy, 17000)
    `CHK("calStart", 1'b1, n > 16000)
    `WAITF(!calBusy, 100)
    `CHK("calLength", CALC, n)
    `CHK("calDone", 1'b1, calDone)
    `CHK("tickRun", 1'b1, tickCount > t0)
    timerStart = 8'hFF;
    step(1);
    timerStart = 8'h00;
    timerStop = 8'h08;
    step(1);
    timerStop = 8'h00;
    `CHK("timerRunning", 8'hF7, timerRunning)
    `WAITF(timeoutEvent != 8'h00, 400)
    `CHK("timeoutEvent", 8'hF7, timeoutEvent)
    `CHK("timerStep", 1'b1, n > 120 && n < 200)
    step(1);
    `CHK("timeoutEvent", 8'h00, timeoutEvent)
    `CHK("timerRunning", 8'h00, timerRunning)
    periphOpen = 7'h7F;
    for (int i = 0; i < 2; i++) begin
      wakeSense = (i == 0) ? 8'h01 : 8'h00;
      nearfieldSense = (i == 1);
      sleepReq = 1'b1;
      `WAITF(deepSleep, 10)
      sleepReq = 1'b0;
      step(5);
      `CHK("periphEnable", 7'h00, periphEnable)
      wakePins[1] = ~wakePins[1];
      step(6);
      `CHK("deepSleep", 1'b1, deepSleep)
      if (i == 0) wakePins[0] = ~wakePins[0];
      else nearfieldPinB = ~nearfieldPinB;
      `WAITF(wakeReset, 8)
      `CHK("wakeReset", 1'b1, wakeReset)
      `CHK("standby", 1'b1, standby)
    end
    for (int i = 0; i < 2; i++) begin
      {brownout, powerFail} = 2'(i + 1);
      step(4);
      `CHK("supplyHold", 1'b1, supplyHold)
      `CHK("periphEnable", 7'h00, periphEnable)
      `CHK("regLoadEnable", 1'b0, regLoadEnable)
      {brownout, powerFail} = 2'h0;
      step(5);
      `CHK("supplyHold", 1'b0, supplyHold)
    end
    give_verdict();
  end
endmodule // lowfreq_timer_calibration_tb_top
bind lowfreq_timer_calibration lowfreq_timer_monitor #(.CAL_CYCLES(CAL_CYCLES)) mon_u (.*);
`default_nettype wire

// >>> tb/lowfreq_timer_monitor.sv
/*
  port checker for lowfreq_timer_calibration.
  assumes ce is held high by the bench and binding to the block top.
*/
`default_nettype none
module lowfreq_timer_monitor #(
  parameter int unsigned CAL_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        calIntervalLoad,
  input wire logic [6:0]  calIntervalValue,
  input wire logic [6:0]  calInterval,
  input wire logic        calBusy,
  input wire logic        calDone,
  input wire logic [7:0]  timerRunning,
  input wire logic [7:0]  timeoutEvent,
  input wire logic [30:0] tickCount,
  input wire logic [6:0]  periphOpen,
  input wire logic [6:0]  periphEnable,
  input wire logic        brownout,
  input wire logic        supplyHold,
  input wire logic        hvMode,
  input wire logic        regOutEnable,
  input wire logic        regLoadEnable,
  input wire logic        regVoltLoad,
  input wire logic [2:0]  regVoltValue,
  input wire logic [2:0]  regVoltSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // run length counted here: a long repetition would be slow to unroll
  logic [31:0] busyCnt;
  logic [31:0] next_busyCnt;
  always_comb next_busyCnt = calBusy ? busyCnt + 32'h1 : 32'h0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busyCnt <= 32'h0;
    else busyCnt <= next_busyCnt;
  end
  property p_cal_len; $fell(calBusy) |-> busyCnt == CAL_CYCLES; endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal run length");
  property p_done; calDone |-> $fell(calBusy); endproperty
  a_done: assert property (p_done) else $error("cal done pulse");
  property p_rst_int; $fell(rst) |-> calInterval == 7'h20; endproperty
  a_rst_int: assert property (p_rst_int) else $error("interval reset");
  property p_int_load;
    ce && calIntervalLoad && calIntervalValue != 7'h00 |=> calInterval == $past(calIntervalValue);
  endproperty
  a_int_load: assert property (p_int_load) else $error("interval load");
  property p_int_legal; calInterval != 7'h00; endproperty
  a_int_legal: assert property (p_int_legal) else $error("interval zero");
  property p_tick;
    tickCount == $past(tickCount) || tickCount == $past(tickCount) + 31'h1;
  endproperty
  a_tick: assert property (p_tick) else $error("tick step");
  property p_timer_ev; (timeoutEvent & ~($past(timerRunning) & ~timerRunning)) == 8'h00; endproperty
  a_timer_ev: assert property (p_timer_ev) else $error("timeout event");
  property p_periph; (periphEnable & ~$past(periphOpen)) == 7'h00; endproperty
  a_periph: assert property (p_periph) else $error("periph enable");
  property p_volt; ce && regVoltLoad && regVoltValue <= 3'h5 |=> regVoltSel == $past(regVoltValue);
  endproperty
  a_volt: assert property (p_volt) else $error("volt select");
  property p_reg_load; regLoadEnable |-> $past(hvMode && regOutEnable); endproperty
  a_reg_load: assert property (p_reg_load) else $error("reg load enable");
  property p_supply; (ce && brownout) [*4] |-> supplyHold; endproperty
  a_supply: assert property (p_supply) else $error("supply hold");
endmodule // lowfreq_timer_monitor
`default_nettype wire
